// ===== sfpm_pkg.sv
// Package for the supply fault protection manager: map, fields, timing.
// Assumes a 250 MHz core clock and 32-bit AXI4-Lite register access.
package sfpm_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] DEVSTAT_OFS = 8'h04;
    localparam logic [7:0] SUPSTAT_OFS = 8'h08;
    localparam logic [7:0] IRQSTAT_OFS = 8'h0c;
    localparam logic [7:0] IRQMASK_OFS = 8'h10;

    // Control register fields
    localparam int RETRY_SEL_LSB = 0;
    localparam int OCP_SEL_LSB   = 4;
    localparam int REF_EN_BIT    = 8;
    localparam int CLEAR_BIT     = 12;

    // Device status register fields
    localparam int FAULT_BIT = 0;
    localparam int UVSUM_BIT = 1;
    localparam int OCSUM_BIT = 2;
    localparam int POR_BIT   = 3;

    // Supply status register fields
    localparam int RIN_UV_BIT  = 0;
    localparam int ROUT_UV_BIT = 1;
    localparam int CHARGE_PUMP_UNDERVOLTAGE_BIT   = 2;
    localparam int REF_UV_BIT  = 3;
    localparam int OCP_PH_LSB  = 4;

    // Interrupt status fields
    localparam int IRQ_UV_BIT  = 0;
    localparam int IRQ_OCP_BIT = 1;
    localparam int IRQ_REC_BIT = 2;

    // Reset values
    localparam logic [2:0] RETRY_SEL_RST = 3'h0;
    localparam logic [2:0] OCP_SEL_RST   = 3'h0;
    localparam logic       REF_EN_RST    = 1'b0;
    localparam logic [2:0] IRQMASK_RST   = 3'h0;

    // Selector encodings
    localparam logic [2:0] SEL_SLOW    = 3'h0;
    localparam logic [2:0] SEL_FAST    = 3'h1;
    localparam logic [2:0] OCP_LATCH   = 3'h2;
    localparam logic [2:0] OCP_REPORT  = 3'h3;
    localparam logic [2:0] OCP_OFF     = 3'h7;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing
    localparam int CLK_MHZ      = 250;
    localparam int FAST_RETRY_MS = 5;
    localparam int SLOW_RETRY_MS = 50;
    localparam int FAST_RETRY_CYC = FAST_RETRY_MS * CLK_MHZ * 1000;
    localparam int SLOW_RETRY_CYC = SLOW_RETRY_MS * CLK_MHZ * 1000;

    typedef struct packed {
        logic       ref_en;
        logic [2:0] ocp_sel;
        logic [2:0] retry_sel;
    } sfpm_ctrl_s;

endpackage : sfpm_pkg

// ===== sfpm_top.sv
// Supply fault protection manager: undervoltage and overcurrent supervision.
// Assumes asynchronous supply comparators and pins; AXI4-Lite on core clock.
`timescale 1ns/1ps

// Operation
// RULE_01 - Motor supply lockout turns off the bridge, charge pump and logic.
// RULE_02 - The driver resumes by itself once the motor supply recovers.
// RULE_03 - The power-on-reset flag reads low after recovery until a clear.
// RULE_04 - Regulator-input undervoltage stops bridge and serial port and flags it.
// RULE_05 - Regulator-input recovery plus retry period restarts and clears its flag.
// RULE_06 - Regulator-output undervoltage stops bridge and serial port and flags it.
// RULE_07 - Regulator-output recovery plus retry period restarts and clears its flag.
// RULE_08 - Fault and undervoltage summaries stay set until a clear.
// RULE_09 - Retry select 000b picks the slow period and 001b the fast one.
// RULE_10 - Regulator and charge-pump undervoltage checks cannot be turned off.
// RULE_11 - Reference undervoltage check is off at reset and needs its enable bit.
// RULE_12 - Pin-configured parts ignore the reference check and use the fast period.
// RULE_13 - Reference undervoltage stops only the sense amplifiers and flags it.
// RULE_14 - Overcurrent select 010b latches off until condition gone and a clear.
// RULE_15 - Overcurrent select 000b or 001b retries after slow or fast period.
// RULE_16 - Overcurrent select 011b only reports and keeps driving.
// RULE_17 - The retry timer restarts whenever the condition comes back.
module sfpm_top #(
    parameter int FAST_CYC = sfpm_pkg::FAST_RETRY_CYC,
    parameter int SLOW_CYC = sfpm_pkg::SLOW_RETRY_CYC
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        pin_variant_in,
    input  wire logic        motor_supply_low_in,
    input  wire logic        regulator_input_undervoltage_in,
    input  wire logic        regulator_output_undervoltage_in,
    input  wire logic        charge_pump_undervoltage_in,
    input  wire logic        sense_reference_undervoltage_in,
    input  wire logic [2:0]  overcurrent_in,
    input  wire logic        sleep_pin_active_low_in,
    output logic             bridge_enable_out,
    output logic             charge_pump_enable_out,
    output logic             logic_enable_out,
    output logic             serial_enable_out,
    output logic             sense_amp_enable_out,
    output logic             fault_pin_active_low_out,
    output logic             fault_pin_oe_out,
    output logic             irq_out,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // Two-stage synchronisers for all asynchronous inputs
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] async_w;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    assign async_w = {pin_variant_in, sleep_pin_active_low_in, overcurrent_in,
                      sense_reference_undervoltage_in, charge_pump_undervoltage_in,
                      regulator_output_undervoltage_in, regulator_input_undervoltage_in,
                      motor_supply_low_in};

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            // Sleep pin idles high in both stages, so no false clear pulse
            sync1_reg <= 10'h100;
            sync2_reg <= 10'h100;
        end
        else
        begin
            sync1_reg <= async_w;
            sync2_reg <= sync1_reg;
        end
    end

    logic       vm_low_w;
    logic       rin_w;
    logic       rout_w;
    logic       cp_w;
    logic       ref_w;
    logic [2:0] ocp_w;
    logic       sleep_w;
    logic       variant_w;
    assign vm_low_w  = sync2_reg[0];
    assign rin_w     = sync2_reg[1];
    assign rout_w    = sync2_reg[2];
    assign cp_w      = sync2_reg[3];
    assign ref_w     = sync2_reg[4];
    assign ocp_w     = sync2_reg[7:5];
    assign sleep_w   = sync2_reg[8];
    assign variant_w = sync2_reg[9];

    // Strap sampled until the synchroniser has filled after reset
    logic       pin_var_reg;
    logic [1:0] strap_cnt_reg;
    logic       sleep_d_reg;
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pin_var_reg    <= 1'b0;
            strap_cnt_reg  <= 2'h0;
            sleep_d_reg    <= 1'b1;
        end
        else
        begin
            if (strap_cnt_reg != 2'h3)
            begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
                pin_var_reg   <= variant_w;
            end
            sleep_d_reg <= sleep_w;
        end
    end

    // Registers
    sfpm_pkg::sfpm_ctrl_s ctrl_reg;
    logic [2:0]           irq_stat_reg;
    logic [2:0]           irq_mask_reg;
    logic                 fault_sum_reg;
    logic                 uv_sum_reg;
    logic                 oc_sum_reg;
    logic                 por_reg;
    logic [3:0]           uv_flag_reg;
    logic [2:0]           oc_flag_reg;
    logic                 oc_latch_reg;
    logic [31:0]          uv_cnt_reg;
    logic [31:0]          oc_cnt_reg;
    logic                 vm_low_d_reg;

    // AXI write decode
    logic       wr_go_w;
    logic       clr_cmd_w;
    logic       clear_w;
    logic [7:0] wofs_w;
    assign wr_go_w       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go_w;
    assign s_axi_wready  = wr_go_w;
    assign wofs_w        = {s_axi_awaddr[7:2], 2'b00};

    function automatic logic mapped(input logic [7:0] ofs);
        mapped = (ofs == sfpm_pkg::CTRL_OFS) || (ofs == sfpm_pkg::DEVSTAT_OFS) ||
                 (ofs == sfpm_pkg::SUPSTAT_OFS) || (ofs == sfpm_pkg::IRQSTAT_OFS) ||
                 (ofs == sfpm_pkg::IRQMASK_OFS);
    endfunction : mapped

    logic wr_ctrl_w;
    logic wr_istat_w;
    logic wr_imask_w;
    assign wr_ctrl_w  = wr_go_w && wofs_w == sfpm_pkg::CTRL_OFS && s_axi_wstrb[0];
    assign wr_istat_w = wr_go_w && wofs_w == sfpm_pkg::IRQSTAT_OFS && s_axi_wstrb[0];
    assign wr_imask_w = wr_go_w && wofs_w == sfpm_pkg::IRQMASK_OFS && s_axi_wstrb[0];
    assign clr_cmd_w  = wr_go_w && wofs_w == sfpm_pkg::CTRL_OFS && s_axi_wstrb[1] &&
                        s_axi_wdata[sfpm_pkg::CLEAR_BIT];
    assign clear_w    = clr_cmd_w || (sleep_d_reg && !sleep_w);

    // Fault detection and retry selection
    logic       ref_act_w;
    logic       uv_cond_w;
    logic       drv_uv_w;
    logic [31:0] uv_per_w;
    logic [31:0] oc_per_w;
    logic [3:0] uv_now_w;
    logic       oc_ev_w;
    logic       oc_on_w;
    logic       oc_retry_w;
    logic       uv_expire_w;
    logic       oc_expire_w;
    assign ref_act_w = ctrl_reg.ref_en && !pin_var_reg && ref_w;            // RULE_11 RULE_12
    assign uv_now_w  = {ref_act_w, cp_w, rout_w, rin_w};                     // RULE_10
    assign uv_cond_w = |uv_now_w;
    assign drv_uv_w  = |uv_flag_reg[2:0];
    assign uv_per_w  = (pin_var_reg || ctrl_reg.retry_sel == sfpm_pkg::SEL_FAST) ?
                       32'(FAST_CYC) : 32'(SLOW_CYC);                         // RULE_09 RULE_12
    assign oc_per_w  = (pin_var_reg || ctrl_reg.ocp_sel == sfpm_pkg::SEL_FAST) ?
                       32'(FAST_CYC) : 32'(SLOW_CYC);                         // RULE_15
    assign oc_on_w   = !pin_var_reg ? ctrl_reg.ocp_sel != sfpm_pkg::OCP_OFF : 1'b1;
    assign oc_retry_w = pin_var_reg || ctrl_reg.ocp_sel == sfpm_pkg::SEL_SLOW ||
                        ctrl_reg.ocp_sel == sfpm_pkg::SEL_FAST;
    assign oc_ev_w   = oc_on_w && |ocp_w;
    assign uv_expire_w = |uv_flag_reg && !uv_cond_w && uv_cnt_reg + 32'h1 >= uv_per_w;
    assign oc_expire_w = oc_retry_w && |oc_flag_reg && !oc_ev_w &&
                         oc_cnt_reg + 32'h1 >= oc_per_w;

    // Retry timers
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            uv_cnt_reg <= 32'h0;
            oc_cnt_reg <= 32'h0;
        end
        else
        begin
            if (uv_cond_w || !(|uv_flag_reg) || uv_expire_w)
                uv_cnt_reg <= 32'h0;                                          // RULE_17
            else
                uv_cnt_reg <= uv_cnt_reg + 32'h1;
            if (oc_ev_w || !(|oc_flag_reg) || oc_expire_w)
                oc_cnt_reg <= 32'h0;
            else
                oc_cnt_reg <= oc_cnt_reg + 32'h1;
        end
    end

    // Fault flags
    logic [2:0] oc_next;
    always_comb
    begin
        oc_next = oc_flag_reg;
        if (oc_expire_w)
            oc_next = 3'h0;                                                   // RULE_15
        else if (clear_w && !oc_retry_w && !oc_ev_w)
            oc_next = 3'h0;                                                   // RULE_14 RULE_16
        if (oc_on_w)
            oc_next = oc_next | ocp_w;
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            uv_flag_reg   <= 4'h0;
            oc_flag_reg   <= 3'h0;
            oc_latch_reg  <= 1'b0;
            fault_sum_reg <= 1'b0;
            uv_sum_reg    <= 1'b0;
            oc_sum_reg    <= 1'b0;
            por_reg       <= 1'b0;
            vm_low_d_reg  <= 1'b0;
        end
        else
        begin
            vm_low_d_reg <= vm_low_w;
            uv_flag_reg  <= (uv_expire_w ? 4'h0 : uv_flag_reg) | uv_now_w; // RULE_04 RULE_05 RULE_06 RULE_07 RULE_13
            oc_flag_reg  <= oc_next;
            if (oc_ev_w && ctrl_reg.ocp_sel == sfpm_pkg::OCP_LATCH && !pin_var_reg)
                oc_latch_reg <= 1'b1;                                         // RULE_14
            else if (clear_w && !oc_ev_w)
                oc_latch_reg <= 1'b0;
            fault_sum_reg <= (fault_sum_reg && !clear_w) || uv_cond_w || oc_ev_w; // RULE_08
            uv_sum_reg    <= (uv_sum_reg && !clear_w) || uv_cond_w;           // RULE_08
            oc_sum_reg    <= (oc_sum_reg && !clear_w) || oc_ev_w;
            if (vm_low_w)
                por_reg <= 1'b0;                                              // RULE_03
            else if (clear_w)
                por_reg <= 1'b1;
        end
    end

    // Driver enables and fault pin
    logic bridge_off_w;
    assign bridge_off_w = vm_low_w || drv_uv_w ||
                          (oc_retry_w && |oc_flag_reg) || oc_latch_reg;      // RULE_14 RULE_15 RULE_16
    assign bridge_enable_out      = !bridge_off_w;                            // RULE_01 RULE_02
    assign charge_pump_enable_out = !vm_low_w && !uv_flag_reg[sfpm_pkg::CHARGE_PUMP_UNDERVOLTAGE_BIT]; // RULE_01
    assign logic_enable_out       = !vm_low_w;                                // RULE_01
    assign serial_enable_out      = !vm_low_w && !uv_flag_reg[0] && !uv_flag_reg[1]; // RULE_04 RULE_06
    assign sense_amp_enable_out   = !vm_low_w && !uv_flag_reg[sfpm_pkg::REF_UV_BIT]; // RULE_13
    assign fault_pin_oe_out       = !vm_low_w && (|uv_flag_reg || |oc_flag_reg || oc_latch_reg);
    assign fault_pin_active_low_out = 1'b0;

    // Control and interrupt registers
    logic [2:0] irq_ev_w;
    assign irq_ev_w = {uv_expire_w || oc_expire_w, oc_ev_w && !(|oc_flag_reg),
                       uv_cond_w && !(|uv_flag_reg)};
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ctrl_reg     <= '{ref_en: sfpm_pkg::REF_EN_RST, ocp_sel: sfpm_pkg::OCP_SEL_RST,
                              retry_sel: sfpm_pkg::RETRY_SEL_RST};
            irq_mask_reg <= sfpm_pkg::IRQMASK_RST;
            irq_stat_reg <= 3'h0;
        end
        else
        begin
            if (wr_ctrl_w)
            begin
                ctrl_reg.retry_sel <= s_axi_wdata[sfpm_pkg::RETRY_SEL_LSB +: 3];
                ctrl_reg.ocp_sel   <= s_axi_wdata[sfpm_pkg::OCP_SEL_LSB +: 3];
            end
            if (wr_go_w && wofs_w == sfpm_pkg::CTRL_OFS && s_axi_wstrb[1])
                ctrl_reg.ref_en <= s_axi_wdata[sfpm_pkg::REF_EN_BIT];         // RULE_11
            if (wr_imask_w)
                irq_mask_reg <= s_axi_wdata[2:0];
            irq_stat_reg <= (irq_stat_reg & ~(wr_istat_w ? s_axi_wdata[2:0] : 3'h0)) | irq_ev_w;
        end
    end
    assign irq_out = |(irq_stat_reg & irq_mask_reg);

    // AXI responses
    logic [7:0]  rofs_w;
    logic [31:0] rd_w;
    assign rofs_w        = {s_axi_araddr[7:2], 2'b00};
    assign s_axi_arready = !s_axi_rvalid;
    always_comb
    begin
        rd_w = 32'h0;
        case (rofs_w)
            sfpm_pkg::CTRL_OFS:    rd_w = {23'h0, ctrl_reg.ref_en, 1'b0, ctrl_reg.ocp_sel,
                                           1'b0, ctrl_reg.retry_sel};
            sfpm_pkg::DEVSTAT_OFS: rd_w = {28'h0, por_reg, oc_sum_reg, uv_sum_reg, fault_sum_reg};
            sfpm_pkg::SUPSTAT_OFS: rd_w = {25'h0, oc_flag_reg, uv_flag_reg};
            sfpm_pkg::IRQSTAT_OFS: rd_w = {29'h0, irq_stat_reg};
            sfpm_pkg::IRQMASK_OFS: rd_w = {29'h0, irq_mask_reg};
            default:               rd_w = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= sfpm_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= sfpm_pkg::RESP_OKAY;
            s_axi_rdata  <= 32'h0;
        end
        else
        begin
            if (wr_go_w)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(wofs_w) ? sfpm_pkg::RESP_OKAY : sfpm_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_w;
                s_axi_rresp  <= mapped(rofs_w) ? sfpm_pkg::RESP_OKAY : sfpm_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    vm_lockout_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE_01
        vm_low_w |-> !bridge_enable_out && !charge_pump_enable_out && !logic_enable_out)
        else $error("bridge not off under motor lockout");
    vm_resume_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE_02
        $fell(vm_low_w) && !(|uv_flag_reg) && !(|oc_flag_reg) && !oc_latch_reg
        |-> bridge_enable_out && charge_pump_enable_out)
        else $error("driver not resumed after motor supply return");
    por_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE_03
        $past(vm_low_w) && !clear_w ##1 !clear_w |-> !por_reg)
        else $error("power-on flag set without clear");
    rin_fault_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE_04
        rin_w && !vm_low_w |=> !bridge_enable_out && !serial_enable_out && fault_pin_oe_out
        && uv_sum_reg && fault_sum_reg)
        else $error("input undervoltage not acted upon");
    uv_restart_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE_05
        uv_expire_w |=> uv_flag_reg == 4'h0 && uv_cnt_reg == 32'h0)
        else $error("undervoltage flags not cleared at retry end");
    rout_fault_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE_06
        rout_w |=> uv_flag_reg[sfpm_pkg::ROUT_UV_BIT] [*1] ##0 !serial_enable_out)
        else $error("output undervoltage not flagged");
    summary_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE_08
        uv_sum_reg && !clear_w |=> uv_sum_reg && fault_sum_reg)
        else $error("summary flag lost without clear");
    timer_restart_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE_17
        uv_cond_w |=> uv_cnt_reg == 32'h0)
        else $error("retry timer not restarted");
    ref_off_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE_11
        !ctrl_reg.ref_en ##1 !vm_low_w |-> sense_amp_enable_out || $past(uv_flag_reg[3]))
        else $error("reference check active while disabled");
    oc_latch_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE_14
        oc_latch_reg && !clear_w |=> !bridge_enable_out)
        else $error("latched overcurrent released without clear");

endmodule : sfpm_top

// ===== sfpm_mcu_model.sv
// Far-side model: the controller's fault line with its pull-up resistor.
// Assumes the design pulls the line low only while its output enable is high.
`timescale 1ns/1ps
module sfpm_mcu_model (
    input  wire logic fault_pin_active_low_in,
    input  wire logic fault_pin_oe_in,
    output logic      fault_line_out
);
    // Released line floats up to the pull-up level
    assign fault_line_out = fault_pin_oe_in ? fault_pin_active_low_in : 1'b1;
endmodule : sfpm_mcu_model

// ===== sfpm_top_tb_top.sv
// Testbench for the supply fault protection manager, driven over AXI4-Lite.
// Assumes short retry periods set through the design's cycle parameters.
`timescale 1ns/1ps
module sfpm_top_tb_top;
    localparam int FC = 20;
    localparam int SC = 40;
    logic        clk, rst_b, mot, rin, rout, cpu, refu, slp_b, pinv;
    logic [2:0]  oc;
    logic        br, cpe, lge, sre, sae, fpo, foe, irq, fline;
    logic [7:0]  awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rv;
    logic [1:0]  bresp, rresp, rs;
    int          error_cnt, checks_done;

    sfpm_top #(.FAST_CYC(FC), .SLOW_CYC(SC)) DUT (
        .core_clk_in(clk), .rst_b_in(rst_b), .pin_variant_in(pinv),
        .motor_supply_low_in(mot), .regulator_input_undervoltage_in(rin),
        .regulator_output_undervoltage_in(rout), .charge_pump_undervoltage_in(cpu),
        .sense_reference_undervoltage_in(refu), .overcurrent_in(oc),
        .sleep_pin_active_low_in(slp_b), .bridge_enable_out(br),
        .charge_pump_enable_out(cpe), .logic_enable_out(lge), .serial_enable_out(sre),
        .sense_amp_enable_out(sae), .fault_pin_active_low_out(fpo),
        .fault_pin_oe_out(foe), .irq_out(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    sfpm_mcu_model MCU (.fault_pin_active_low_in(fpo), .fault_pin_oe_in(foe),
        .fault_line_out(fline));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do @(posedge clk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge clk); while (!bvalid);
        chk("bresp", {30'h0, bresp}, {30'h0, sfpm_pkg::RESP_OKAY});
    endtask : wr

    task automatic rd(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rv = rdata;
        rs = rresp;
    endtask : rd

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(nm, rv, exp);
    endtask : rchk

    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        {rst_b, mot, rin, rout, cpu, refu, oc, pinv} = '0;
        {awaddr, araddr, awvalid, wvalid, arvalid, wdata} = '0;
        // Responses are always accepted
        {bready, rready} = 2'b11;
        slp_b = 1'b1;
        tick(16);
        rst_b <= 1'b1;
        tick(3);
        rchk("ctrl", sfpm_pkg::CTRL_OFS, 32'h0);
        rchk("devstat", sfpm_pkg::DEVSTAT_OFS, 32'h0);
        rd(8'h14);
        chk("unmapped", {30'h0, rs}, {30'h0, sfpm_pkg::RESP_SLVERR});
        wr(sfpm_pkg::IRQMASK_OFS, 32'h1);
        wr(sfpm_pkg::CTRL_OFS, 32'h1);
        rin <= 1'b1;
        tick(5);
        chk("bridge", br, 1'b0);
        chk("serial", sre, 1'b0);
        chk("fault", fline, 1'b0);
        chk("irq", irq, 1'b1);
        rchk("supstat", sfpm_pkg::SUPSTAT_OFS, 32'h1);
        rchk("devstat", sfpm_pkg::DEVSTAT_OFS, 32'h3);
        rin <= 1'b0;
        tick(10);
        chk("bridge", br, 1'b0);
        tick(FC);
        chk("bridge", br, 1'b1);
        chk("fault", fline, 1'b1);
        rchk("supstat", sfpm_pkg::SUPSTAT_OFS, 32'h0);
        rchk("devstat", sfpm_pkg::DEVSTAT_OFS, 32'h3);
        rout <= 1'b1;
        tick(5);
        chk("serial", sre, 1'b0);
        rchk("supstat", sfpm_pkg::SUPSTAT_OFS, 32'h2);
        rout <= 1'b0;
        tick(10);
        rout <= 1'b1;
        tick(3);
        rout <= 1'b0;
        tick(14);
        chk("bridge", br, 1'b0);
        tick(15);
        chk("bridge", br, 1'b1);
        wr(sfpm_pkg::CTRL_OFS, 32'h0);
        cpu <= 1'b1;
        tick(5);
        chk("bridge", br, 1'b0);
        chk("cp", cpe, 1'b0);
        cpu <= 1'b0;
        tick(FC + 10);
        chk("bridge", br, 1'b0);
        tick(SC);
        chk("bridge", br, 1'b1);
        wr(sfpm_pkg::CTRL_OFS, 32'h1001);
        rchk("devstat", sfpm_pkg::DEVSTAT_OFS, 32'h8);
        rchk("ctrl", sfpm_pkg::CTRL_OFS, 32'h1);
        wr(sfpm_pkg::IRQMASK_OFS, 32'h0);
        chk("irq", irq, 1'b0);
        wr(sfpm_pkg::IRQSTAT_OFS, 32'h7);
        wr(sfpm_pkg::IRQMASK_OFS, 32'h7);
        chk("irq", irq, 1'b0);
        refu <= 1'b1;
        tick(5);
        chk("sense", sae, 1'b1);
        chk("fault", fline, 1'b1);
        wr(sfpm_pkg::CTRL_OFS, 32'h101);
        tick(5);
        chk("sense", sae, 1'b0);
        chk("bridge", br, 1'b1);
        chk("fault", fline, 1'b0);
        rchk("supstat", sfpm_pkg::SUPSTAT_OFS, 32'h8);
        refu <= 1'b0;
        tick(FC + 10);
        chk("sense", sae, 1'b1);
        mot <= 1'b1;
        tick(5);
        chk("enables", {br, cpe, lge}, 3'h0);
        mot <= 1'b0;
        tick(5);
        chk("bridge", br, 1'b1);
        rd(sfpm_pkg::DEVSTAT_OFS);
        chk("por", rv[sfpm_pkg::POR_BIT], 1'b0);
        wr(sfpm_pkg::CTRL_OFS, 32'h1021);
        oc <= 3'h1;
        tick(5);
        chk("bridge", br, 1'b0);
        oc <= 3'h0;
        tick(SC + 10);
        chk("bridge", br, 1'b0);
        wr(sfpm_pkg::CTRL_OFS, 32'h1031);
        tick(3);
        chk("bridge", br, 1'b1);
        oc <= 3'h4;
        tick(5);
        chk("bridge", br, 1'b1);
        chk("fault", fline, 1'b0);
        oc <= 3'h0;
        tick(3);
        wr(sfpm_pkg::CTRL_OFS, 32'h1011);
        tick(3);
        chk("fault", fline, 1'b1);
        oc <= 3'h2;
        tick(5);
        chk("bridge", br, 1'b0);
        oc <= 3'h0;
        tick(FC + 10);
        chk("bridge", br, 1'b1);
        rchk("supstat", sfpm_pkg::SUPSTAT_OFS, 32'h0);
        rd(sfpm_pkg::DEVSTAT_OFS);
        chk("ocsum", rv[sfpm_pkg::OCSUM_BIT], 1'b1);
        slp_b <= 1'b0;
        tick(3);
        slp_b <= 1'b1;
        tick(5);
        rchk("devstat", sfpm_pkg::DEVSTAT_OFS, 32'h8);
        // Mid-run reset into the pin-configured variant
        pinv  <= 1'b1;
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        tick(3);
        rchk("devstat", sfpm_pkg::DEVSTAT_OFS, 32'h0);
        cpu <= 1'b1;
        tick(5);
        chk("bridge", br, 1'b0);
        cpu <= 1'b0;
        tick(FC + 10);
        chk("bridge", br, 1'b1);
        wr(sfpm_pkg::CTRL_OFS, 32'h100);
        refu <= 1'b1;
        tick(5);
        chk("sense", sae, 1'b1);
        chk("fault", fline, 1'b1);
        report_and_stop();
    end
endmodule : sfpm_top_tb_top
